// [shared/adcss_defines.svh]
// Register layout, reset values and lookup constants of the channel select block
`ifndef ADCSS_DEFINES_SVH
`define ADCSS_DEFINES_SVH

`define ADCSS_REG_W               10
`define ADCSS_CR0_RESET           10'h020
`define ADCSS_CR1_RESET           10'h030
`define ADCSS_CR1_WMASK           10'h1FC

`define ADCSS_CR0_EXT_REF         0
`define ADCSS_CR0_SINGLE_CONV     1
`define ADCSS_CR0_POWER_DOWN      2
`define ADCSS_CR0_INPUT_PICK_LO   3
`define ADCSS_CR0_INPUT_PICK_HI   4
`define ADCSS_CR0_PAIR_COUNT_LO   5
`define ADCSS_CR0_PAIR_COUNT_HI   6
`define ADCSS_CR0_AUTOSCAN        7
`define ADCSS_CR0_SELFCHECK_LO    8
`define ADCSS_CR0_SELFCHECK_HI    9

`define ADCSS_CR1_SOFT_RESET      0
`define ADCSS_CR1_OVERRUN_CLEAR   1
`define ADCSS_CR1_FILL_LEVEL_LO   2
`define ADCSS_CR1_FILL_LEVEL_HI   3
`define ADCSS_CR1_AVAIL_PULSE     4
`define ADCSS_CR1_AVAIL_HIGH      5
`define ADCSS_CR1_RW_PIN_MODE     6
`define ADCSS_CR1_NUMBER_FORMAT   7
`define ADCSS_CR1_OFFSET_CAL      8
`define ADCSS_CR1_RESERVED        9

`define ADCSS_ADDR_CR0            2'h0
`define ADCSS_ADDR_CR1            2'h1

`define ADCSS_FIFO_DEPTH          16
`define ADCSS_SAMPLE_W            10
`define ADCSS_TAG_W               4

// Fill level per channel count, four 5-bit entries, selector 3 in the top slot
`define ADCSS_TRIG_1CH            20'h7_2081
`define ADCSS_TRIG_2CH            20'h6_2082
`define ADCSS_TRIG_3CH            20'h6_24C3
`define ADCSS_TRIG_4CH            20'h0_3104

`endif

// [shared/adcss_pkg.sv]
// Types shared by the channel select block
package adcss_pkg;

	typedef enum logic [3:0] {
		adcss_in_none,
		adcss_in_a_pos,
		adcss_in_a_neg,
		adcss_in_b_pos,
		adcss_in_b_neg,
		adcss_in_diff_a,
		adcss_in_diff_b,
		adcss_in_ref_hi,
		adcss_in_ref_mid,
		adcss_in_ref_lo
	} adcss_input_t;

	typedef enum logic [1:0] {
		adcss_test_off,
		adcss_test_upper,
		adcss_test_mid,
		adcss_test_lower
	} adcss_test_t;

endpackage

// [rtl/adcss_fifo.sv]
// Flip-flop FIFO with valid/ready on both sides and a synchronous clear
`timescale 1ns/1ps
`default_nettype none

module adcss_fifo #(
	parameter int WIDTH = 14,
	parameter int DEPTH = 16
) (
	input  wire logic                       clk,
	input  wire logic                       rst,
	input  wire logic                       clear,
	input  wire logic [WIDTH-1:0]           in_data,
	input  wire logic                       in_valid,
	output logic                            in_ready,
	output logic      [WIDTH-1:0]           out_data,
	output logic                            out_valid,
	input  wire logic                       out_ready,
	output logic      [$clog2(DEPTH+1)-1:0] count
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH+1);

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0]    wr_reg;
	logic [AW-1:0]    wr_next;
	logic [AW-1:0]    rd_reg;
	logic [AW-1:0]    rd_next;
	logic [CW-1:0]    cnt_reg;
	logic [CW-1:0]    cnt_next;
	logic             push;
	logic             pop;

	assign in_ready  = (cnt_reg != CW'(DEPTH));
	assign out_valid = (cnt_reg != '0);
	assign out_data  = mem_reg[rd_reg];
	assign count     = cnt_reg;
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_comb begin
		wr_next  = wr_reg;
		rd_next  = rd_reg;
		cnt_next = cnt_reg;
		if (clear) begin
			wr_next  = '0;
			rd_next  = '0;
			cnt_next = '0;
		end else begin
			if (push)
				wr_next = (wr_reg == AW'(DEPTH-1)) ? '0 : wr_reg + 1'b1;
			if (pop)
				rd_next = (rd_reg == AW'(DEPTH-1)) ? '0 : rd_reg + 1'b1;
			if (push && !pop)
				cnt_next = cnt_reg + 1'b1;
			else if (pop && !push)
				cnt_next = cnt_reg - 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			wr_reg  <= '0;
			rd_reg  <= '0;
			cnt_reg <= '0;
		end else begin
			wr_reg  <= wr_next;
			rd_reg  <= rd_next;
			cnt_reg <= cnt_next;
		end
	end

	// Storage holds no reset; emptiness is carried by the counter
	always_ff @(posedge clk) begin
		if (push && !clear)
			mem_reg[wr_reg] <= in_data;
	end

endmodule

`default_nettype wire

// [rtl/adcss_scan_seq.sv]
// Decodes the input selection fields into a fixed input or an autoscan sequence
`timescale 1ns/1ps
`default_nettype none

module adcss_scan_seq (
	input  wire logic                 clk,
	input  wire logic                 rst,
	input  wire logic                 autoscan,
	input  wire logic                 pair_hi,
	input  wire logic                 pair_lo,
	input  wire logic [1:0]           pick,
	input  wire logic                 step,
	output adcss_pkg::adcss_input_t   cur_input,
	output logic      [2:0]           chan_count
);
	logic [4:0]                 key;
	logic [4:0]                 key_reg;
	logic [1:0]                 pos_reg;
	logic [1:0]                 pos_next;
	logic [2:0]                 len;
	adcss_pkg::adcss_input_t    slot [4];

	assign key = {autoscan, pair_hi, pair_lo, pick};

	always_comb begin
		len = 3'd1;
		for (int i = 0; i < 4; i++)
			slot[i] = adcss_pkg::adcss_in_none;
		case (key)
			5'h00: slot[0] = adcss_pkg::adcss_in_a_pos;  // [R1] [R4]
			5'h01: slot[0] = adcss_pkg::adcss_in_a_neg;  // [R4]
			5'h02: slot[0] = adcss_pkg::adcss_in_b_pos;  // [R4]
			5'h03: slot[0] = adcss_pkg::adcss_in_b_neg;  // [R4]
			5'h04: slot[0] = adcss_pkg::adcss_in_diff_a; // [R2] [R5]
			5'h05: slot[0] = adcss_pkg::adcss_in_diff_b; // [R5]
			5'h11: begin // [R3] [R6]
				len     = 3'd2;
				slot[0] = adcss_pkg::adcss_in_a_pos;
				slot[1] = adcss_pkg::adcss_in_a_neg;
			end
			5'h12: begin // [R7]
				len     = 3'd3;
				slot[0] = adcss_pkg::adcss_in_a_pos;
				slot[1] = adcss_pkg::adcss_in_a_neg;
				slot[2] = adcss_pkg::adcss_in_b_pos;
			end
			5'h13: begin // [R8]
				len     = 3'd4;
				slot[0] = adcss_pkg::adcss_in_a_pos;
				slot[1] = adcss_pkg::adcss_in_a_neg;
				slot[2] = adcss_pkg::adcss_in_b_pos;
				slot[3] = adcss_pkg::adcss_in_b_neg;
			end
			5'h15: begin // [R9]
				len     = 3'd2;
				slot[0] = adcss_pkg::adcss_in_a_pos;
				slot[1] = adcss_pkg::adcss_in_diff_b;
			end
			5'h16: begin // [R10]
				len     = 3'd3;
				slot[0] = adcss_pkg::adcss_in_a_pos;
				slot[1] = adcss_pkg::adcss_in_a_neg;
				slot[2] = adcss_pkg::adcss_in_diff_b;
			end
			5'h19: begin // [R11]
				len     = 3'd2;
				slot[0] = adcss_pkg::adcss_in_diff_a;
				slot[1] = adcss_pkg::adcss_in_diff_b;
			end
			// Reserved codes park on no input rather than guess a sequence
			default: len = 3'd1; // [R15]
		endcase
	end

	// A changed selection restarts the sequence at its first entry
	always_comb begin
		pos_next = pos_reg;
		if (key != key_reg)
			pos_next = '0;
		else if (step)
			pos_next = ({1'b0, pos_reg} == len - 3'd1) ? 2'd0 : pos_reg + 2'd1;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			pos_reg <= '0;
			key_reg <= 5'h04;
		end else begin
			pos_reg <= pos_next;
			key_reg <= key;
		end
	end

	assign cur_input  = (key != key_reg) ? slot[0] : slot[pos_reg];
	assign chan_count = len; // [R18]

endmodule

`default_nettype wire

// [rtl/adcss_top.sv]
// Control registers, input selection and sample queue of the converter
// Summary of operation
// [R1] Bits 3-4 pick the converted input
// [R2] Bit 5 selects single-ended or differential
// [R3] Bits 6-7 enable autoscan, set pair count
// [R4] Codes 0-3 convert one single-ended input
// [R5] Differential codes 0/1 convert A or B pair
// [R6] Scan code 1: A-pos, A-neg repeating
// [R7] Scan code 2: A-pos, A-neg, B-pos repeating
// [R8] Scan code 3: all four single-ended repeating
// [R9] Mixed code 1: A-pos, B pair repeating
// [R10] Mixed code 2: A-pos, A-neg, B pair
// [R11] Two pairs: A pair, B pair repeating
// [R12] Bits 8-9 zero means normal conversion
// [R13] Test codes convert upper, mid, lower reference
// [R14] Second register bit layout fixed as listed
// [R15] Host avoids reserved channel configurations
// [R16] Address 00 first register, 01 second
// [R17] Reading second register clears overflow flag
// [R18] Each pair or single input counts once
`timescale 1ns/1ps
`default_nettype none
`include "adcss_defines.svh"

module adcss_top #(
	parameter int FIFO_DEPTH = `ADCSS_FIFO_DEPTH,
	parameter int SAMPLE_W   = `ADCSS_SAMPLE_W
) (
	input  wire logic                          clk,
	input  wire logic                          rst,
	input  wire logic                          reg_addr_lo,
	input  wire logic                          reg_addr_hi,
	input  wire logic [`ADCSS_REG_W-1:0]       data_in,
	output logic      [`ADCSS_REG_W-1:0]       data_out,
	output logic                               data_out_valid,
	input  wire logic                          access,
	input  wire logic                          rd_sel,
	input  wire logic                          wr_sel,
	input  wire logic                          conv_strobe,
	output adcss_pkg::adcss_input_t            active_input,
	output logic      [2:0]                    chan_count,
	input  wire logic [SAMPLE_W-1:0]           conv_data,
	input  wire logic                          conv_valid,
	output logic                               conv_ready,
	output logic      [SAMPLE_W-1:0]           sample_data,
	output adcss_pkg::adcss_input_t            sample_input,
	output logic                               sample_valid,
	input  wire logic                          sample_ready,
	output logic      [$clog2(FIFO_DEPTH+1)-1:0] fifo_count,
	output logic      [4:0]                    fill_level,
	output logic                               overrun,
	output logic                               ext_ref_sel,
	output logic                               single_conv_mode,
	output logic                               power_down,
	output logic                               avail_pulse_type,
	output logic                               avail_active_high,
	output logic                               rw_pin_mode,
	output logic                               number_format_sel,
	output logic                               offset_cal_en
);
	localparam int TW = `ADCSS_TAG_W;
	localparam int QW = SAMPLE_W + TW;

	logic [`ADCSS_REG_W-1:0] cr0_reg;
	logic [`ADCSS_REG_W-1:0] cr0_next;
	logic [`ADCSS_REG_W-1:0] cr1_reg;
	logic [`ADCSS_REG_W-1:0] cr1_next;
	logic                    ovf_reg;
	logic                    ovf_next;
	logic [`ADCSS_REG_W-1:0] dout_reg;
	logic [`ADCSS_REG_W-1:0] dout_next;
	logic                    dval_reg;
	logic                    dval_next;
	logic                    sreset_reg;
	logic                    sreset_next;
	logic [TW-1:0]           tag_reg;
	logic [TW-1:0]           tag_next;

	logic [1:0]              addr;
	logic                    do_rd;
	logic                    do_wr;
	logic                    hit_cr0;
	logic                    hit_cr1;
	logic                    queue_clear;
	logic                    drop;
	logic [1:0]              test_sel;
	adcss_pkg::adcss_input_t scan_input;
	logic [2:0]              scan_count;
	logic [QW-1:0]           q_out;
	logic [19:0]             trig_row;

	// Host access decode
	assign addr    = {reg_addr_hi, reg_addr_lo};
	assign hit_cr0 = (addr == `ADCSS_ADDR_CR0); // [R16]
	assign hit_cr1 = (addr == `ADCSS_ADDR_CR1); // [R16]

	// In read/write pin mode the write line carries direction and the read line is ignored
	always_comb begin
		do_rd = 1'b0;
		do_wr = 1'b0;
		if (access) begin
			if (cr1_reg[`ADCSS_CR1_RW_PIN_MODE]) begin
				do_rd = wr_sel;
				do_wr = !wr_sel;
			end else begin
				do_rd = rd_sel && !wr_sel;
				do_wr = wr_sel && !rd_sel;
			end
		end
	end

	// Control register state
	always_comb begin
		cr0_next    = cr0_reg;
		cr1_next    = cr1_reg;
		sreset_next = 1'b0;
		if (sreset_reg) begin
			cr0_next = `ADCSS_CR0_RESET;
			cr1_next = `ADCSS_CR1_RESET;
		end else if (do_wr && hit_cr0) begin
			cr0_next = data_in;
		end else if (do_wr && hit_cr1) begin
			// Reset, queue clear and reserved bits are never stored
			cr1_next    = data_in & `ADCSS_CR1_WMASK; // [R14]
			sreset_next = data_in[`ADCSS_CR1_SOFT_RESET]; // [R14]
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			cr0_reg    <= `ADCSS_CR0_RESET;
			cr1_reg    <= `ADCSS_CR1_RESET;
			sreset_reg <= 1'b0;
		end else begin
			cr0_reg    <= cr0_next;
			cr1_reg    <= cr1_next;
			sreset_reg <= sreset_next;
		end
	end

	assign queue_clear = sreset_reg
		|| (do_wr && hit_cr1 && data_in[`ADCSS_CR1_OVERRUN_CLEAR]); // [R14]

	// Overflow flag: a drop in the same cycle as the clearing read keeps the flag set
	// A push refused during a queue clear is dropped silently, never flagged as an overrun
	assign drop = conv_valid && !conv_ready && !queue_clear;

	always_comb begin
		ovf_next = ovf_reg;
		if (sreset_reg)
			ovf_next = 1'b0;
		else if (do_rd && hit_cr1)
			ovf_next = 1'b0; // [R17]
		if (drop)
			ovf_next = 1'b1;
	end

	always_ff @(posedge clk) begin
		if (rst)
			ovf_reg <= 1'b0;
		else
			ovf_reg <= ovf_next;
	end

	// Read data; unmapped addresses read as zero
	always_comb begin
		dout_next = dout_reg;
		dval_next = 1'b0;
		if (do_rd) begin
			dval_next = 1'b1;
			if (hit_cr0)
				dout_next = cr0_reg;
			else if (hit_cr1) begin
				dout_next = cr1_reg;
				dout_next[`ADCSS_CR1_OVERRUN_CLEAR] = ovf_reg; // [R14]
			end else
				dout_next = '0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			dout_reg <= '0;
			dval_reg <= 1'b0;
		end else begin
			dout_reg <= dout_next;
			dval_reg <= dval_next;
		end
	end

	assign data_out       = dout_reg;
	assign data_out_valid = dval_reg;
	assign overrun        = ovf_reg;

	// Input selection and sequencing
	adcss_scan_seq u_scan (
		.clk        (clk),
		.rst        (rst || sreset_reg),
		.autoscan   (cr0_reg[`ADCSS_CR0_AUTOSCAN]), // [R3]
		.pair_hi    (cr0_reg[`ADCSS_CR0_PAIR_COUNT_HI]), // [R3]
		.pair_lo    (cr0_reg[`ADCSS_CR0_PAIR_COUNT_LO]), // [R2]
		.pick       (cr0_reg[`ADCSS_CR0_INPUT_PICK_HI:`ADCSS_CR0_INPUT_PICK_LO]), // [R1]
		.step       (conv_strobe && (test_sel == 2'b00)),
		.cur_input  (scan_input),
		.chan_count (scan_count)
	);

	assign test_sel = cr0_reg[`ADCSS_CR0_SELFCHECK_HI:`ADCSS_CR0_SELFCHECK_LO];

	// Test selection overrides the scan and freezes its position
	always_comb begin
		case (adcss_pkg::adcss_test_t'(test_sel))
			adcss_pkg::adcss_test_off:   active_input = scan_input; // [R12]
			adcss_pkg::adcss_test_upper: active_input = adcss_pkg::adcss_in_ref_hi; // [R13]
			adcss_pkg::adcss_test_mid:   active_input = adcss_pkg::adcss_in_ref_mid; // [R13]
			adcss_pkg::adcss_test_lower: active_input = adcss_pkg::adcss_in_ref_lo; // [R13]
			default:                     active_input = scan_input;
		endcase
	end

	assign chan_count = (test_sel == 2'b00) ? scan_count : 3'd1; // [R18]

	// Tag each result with the input captured at its conversion strobe
	always_comb begin
		tag_next = tag_reg;
		if (conv_strobe)
			tag_next = active_input;
	end

	always_ff @(posedge clk) begin
		if (rst)
			tag_reg <= '0;
		else
			tag_reg <= tag_next;
	end

	// Sample queue; a full queue stalls the converter and counts as an overrun
	adcss_fifo #(
		.WIDTH (QW),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk       (clk),
		.rst       (rst),
		.clear     (queue_clear),
		.in_data   ({tag_reg, conv_data}),
		.in_valid  (conv_valid && !queue_clear),
		.in_ready  (conv_ready),
		.out_data  (q_out),
		.out_valid (sample_valid),
		.out_ready (sample_ready),
		.count     (fifo_count)
	);

	assign sample_data  = q_out[SAMPLE_W-1:0];
	assign sample_input = adcss_pkg::adcss_input_t'(q_out[QW-1:SAMPLE_W]);

	// Fill level threshold depends on how many channels the sequence holds
	always_comb begin
		case (chan_count)
			3'd2:    trig_row = `ADCSS_TRIG_2CH; // [R18]
			3'd3:    trig_row = `ADCSS_TRIG_3CH;
			3'd4:    trig_row = `ADCSS_TRIG_4CH;
			default: trig_row = `ADCSS_TRIG_1CH;
		endcase
	end

	always_comb begin
		case (cr1_reg[`ADCSS_CR1_FILL_LEVEL_HI:`ADCSS_CR1_FILL_LEVEL_LO]) // [R14]
			2'd0:    fill_level = trig_row[4:0];
			2'd1:    fill_level = trig_row[9:5];
			2'd2:    fill_level = trig_row[14:10];
			default: fill_level = trig_row[19:15];
		endcase
	end

	// Configuration bits passed to the converter core
	assign ext_ref_sel       = cr0_reg[`ADCSS_CR0_EXT_REF];
	assign single_conv_mode  = cr0_reg[`ADCSS_CR0_SINGLE_CONV];
	assign power_down        = cr0_reg[`ADCSS_CR0_POWER_DOWN];
	assign avail_pulse_type  = cr1_reg[`ADCSS_CR1_AVAIL_PULSE]; // [R14]
	assign avail_active_high = cr1_reg[`ADCSS_CR1_AVAIL_HIGH]; // [R14]
	assign rw_pin_mode       = cr1_reg[`ADCSS_CR1_RW_PIN_MODE]; // [R14]
	assign number_format_sel = cr1_reg[`ADCSS_CR1_NUMBER_FORMAT]; // [R14]
	assign offset_cal_en     = cr1_reg[`ADCSS_CR1_OFFSET_CAL]; // [R14]

endmodule

`default_nettype wire

// [dv/adcss_top_props.sv]
// Port-level checker of the channel select block
`timescale 1ns/1ps
`default_nettype none
module adcss_top_props #(
	parameter int FIFO_DEPTH = 16
) (
	input	wire logic			clk,
	input	wire logic			rst,
	input	wire logic			reg_addr_lo,
	input	wire logic			reg_addr_hi,
	input	wire logic			access,
	input	wire logic			rd_sel,
	input	wire logic			wr_sel,
	input	wire logic	[9:0]		data_out,
	input	wire logic			data_out_valid,
	input	wire logic			conv_strobe,
	input	wire adcss_pkg::adcss_input_t	active_input,
	input	wire logic	[2:0]		chan_count,
	input	wire logic			conv_valid,
	input	wire logic			conv_ready,
	input	wire logic	[9:0]		sample_data,
	input	wire logic			sample_valid,
	input	wire logic			sample_ready,
	input	wire logic	[$clog2(FIFO_DEPTH+1)-1:0]	fifo_count,
	input	wire logic			overrun,
	input	wire logic			rw_pin_mode
);
	logic	rd_req;
	logic	wr_req;
	logic	is_ref;
	assign rd_req = access && (rw_pin_mode ? wr_sel : rd_sel && !wr_sel);
	assign wr_req = access && (rw_pin_mode ? !wr_sel : wr_sel && !rd_sel);
	assign is_ref = active_input inside {adcss_pkg::adcss_in_ref_hi, adcss_pkg::adcss_in_ref_mid,
		adcss_pkg::adcss_in_ref_lo};
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	read_valid_a: assert property (rd_req |=> data_out_valid)
		else $error("read gave no valid");
	valid_cause_a: assert property (!rd_req |=> !data_out_valid)
		else $error("valid without a read");
	unmapped_zero_a: assert property (rd_req && reg_addr_hi |=> data_out == 10'h000)
		else $error("unmapped read not zero");
	ovf_clear_a: assert property (rd_req && reg_addr_lo && !reg_addr_hi && !(conv_valid && !conv_ready) |=> !overrun)
		else $error("overflow kept after read");
	ovf_set_a: assert property (conv_valid && !conv_ready && !wr_req && !$past(wr_req) |=> overrun)
		else $error("drop did not set overflow");
	ref_count_a: assert property (is_ref |-> chan_count == 3'h1)
		else $error("test input counted wrong");
	ref_hold_a: assert property (is_ref && conv_strobe && !access |=> $stable(active_input))
		else $error("test input moved on strobe");
	chan_range_a: assert property (chan_count inside {[1:4]})
		else $error("channel count out of range");
	full_ready_a: assert property (conv_ready == (fifo_count != FIFO_DEPTH))
		else $error("ready disagrees with fill");
	head_hold_a: assert property (sample_valid && !sample_ready && !access && !$past(access)
		|=> sample_valid && $stable(sample_data))
		else $error("queue head changed while stalled");
endmodule
`default_nettype wire

// [dv/adcss_host.sv]
// Host processor model that drives the register port
`timescale 1ns/1ps
`default_nettype none
module adcss_host (
	input	wire logic		clk,
	input	wire logic		mode,
	output	logic			reg_addr_lo,
	output	logic			reg_addr_hi,
	output	logic	[9:0]		data_in,
	output	logic			access,
	output	logic			rd_sel,
	output	logic			wr_sel
);
	initial begin
		{reg_addr_hi, reg_addr_lo} = 2'h0;
		data_in = 10'h155;
		access = 1'b0;
		rd_sel = 1'b0;
		wr_sel = 1'b0;
	end
	// One strobe cycle, then a gap so no strobe is raised twice in one step
	task automatic xfer(input logic rd, input logic [1:0] a, input logic [9:0] d);
		@(negedge clk);
		{reg_addr_hi, reg_addr_lo} = a;
		data_in = d;
		access = 1'b1;
		rd_sel = rd && !mode;
		wr_sel = mode ? rd : !rd;
		@(negedge clk);
		access = 1'b0;
		rd_sel = 1'b0;
		wr_sel = 1'b0;
		// Released bus shows the inverse, never the stale word
		data_in = ~d;
	endtask
endmodule
`default_nettype wire

// [dv/adc_channel_scan_select_test.sv]
// Self-checking bench of the channel select block
`timescale 1ns/1ps
`default_nettype none
`include "adcss_defines.svh"
module adc_channel_scan_select_test;
	localparam int DEPTH = `ADCSS_FIFO_DEPTH;
	localparam logic [3:0] AP = adcss_pkg::adcss_in_a_pos, AN = adcss_pkg::adcss_in_a_neg,
		BP = adcss_pkg::adcss_in_b_pos, BN = adcss_pkg::adcss_in_b_neg,
		DA = adcss_pkg::adcss_in_diff_a, DB = adcss_pkg::adcss_in_diff_b;
	localparam logic [3:0] REFS [3] = '{adcss_pkg::adcss_in_ref_hi, adcss_pkg::adcss_in_ref_mid,
		adcss_pkg::adcss_in_ref_lo};
	localparam logic [3:0] FX [6] = '{AP, AN, BP, BN, DA, DB};
	localparam logic [9:0] SC [6] = '{10'h088, 10'h090, 10'h098, 10'h0A8, 10'h0B0, 10'h0C8};
	localparam int SN [6] = '{2, 3, 4, 2, 3, 2};
	localparam logic [15:0] SQ [6] = '{{8'h00, AN, AP}, {4'h0, BP, AN, AP}, {BN, BP, AN, AP},
		{8'h00, DB, AP}, {4'h0, DB, AN, AP}, {8'h00, DB, DA}};
	logic			clk, rst, rw_mode, conv_strobe, conv_valid, sample_ready;
	logic	[9:0]		conv_data;
	logic	[3:0]		tag;
	logic	[13:0]		rq [$];
	logic	[13:0]		sq [$];
	int			seed, err_count, cmp_count, i, k;
	wire logic		a_lo, a_hi, acc, rds, wrs, dvalid, conv_ready, sample_valid, overrun;
	wire logic	[9:0]	din, data_out, sample_data;
	wire logic	[3:0]	active_input, sample_input;
	wire logic	[2:0]	chan_count, cr0_pins;
	wire logic	[4:0]	fifo_count, cr1_pins, fill_level;

	adcss_host u_host (.clk(clk), .mode(rw_mode), .reg_addr_lo(a_lo), .reg_addr_hi(a_hi),
		.data_in(din), .access(acc), .rd_sel(rds), .wr_sel(wrs));
	adcss_top u_dut (.clk(clk), .rst(rst), .reg_addr_lo(a_lo), .reg_addr_hi(a_hi), .data_in(din),
		.data_out(data_out), .data_out_valid(dvalid), .access(acc), .rd_sel(rds), .wr_sel(wrs),
		.conv_strobe(conv_strobe), .active_input(active_input), .chan_count(chan_count),
		.conv_data(conv_data), .conv_valid(conv_valid), .conv_ready(conv_ready),
		.sample_data(sample_data), .sample_input(sample_input), .sample_valid(sample_valid),
		.sample_ready(sample_ready), .fifo_count(fifo_count), .fill_level(fill_level),
		.overrun(overrun), .ext_ref_sel(cr0_pins[0]), .single_conv_mode(cr0_pins[1]),
		.power_down(cr0_pins[2]), .avail_pulse_type(cr1_pins[4]),
		.avail_active_high(cr1_pins[3]), .rw_pin_mode(cr1_pins[2]),
		.number_format_sel(cr1_pins[1]), .offset_cal_en(cr1_pins[0]));

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	task automatic chk(input logic [13:0] seen, input logic [13:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic wr(input logic [1:0] a, input logic [9:0] d);
		u_host.xfer(1'b0, a, d);
	endtask
	task automatic rd(input logic [1:0] a, input logic [9:0] exp);
		rq.push_back({4'h0, exp});
		u_host.xfer(1'b1, a, 10'h000);
	endtask
	task automatic strobe;
		@(negedge clk) conv_strobe = 1'b1;
		@(negedge clk) conv_strobe = 1'b0;
	endtask
	task automatic push(input logic [9:0] d);
		@(negedge clk);
		conv_data = d;
		conv_valid = 1'b1;
		if (conv_ready === 1'b1) sq.push_back({tag, d});
		@(negedge clk);
		conv_valid = 1'b0;
		conv_data = ~d;
	endtask

	// Results are matched in arrival order against what the driver noted
	always @(posedge clk) begin
		if (rst === 1'b0 && dvalid === 1'b1)
			chk({4'h0, data_out}, rq.size() ? rq.pop_front() : 14'h3FFF);
		if (rst === 1'b0 && sample_valid === 1'b1 && sample_ready === 1'b1)
			chk({sample_input, sample_data}, sq.size() ? sq.pop_front() : 14'h3FFF);
	end

	initial begin
		seed = 16548;
		err_count = 0;
		cmp_count = 0;
		rst = 1'b1;
		rw_mode = 1'b0;
		conv_strobe = 1'b0;
		conv_valid = 1'b0;
		conv_data = 10'h000;
		sample_ready = 1'b0;
		tag = AP;
		repeat (20) @(posedge clk);
		@(negedge clk) rst = 1'b0;
		chk(active_input, DA);
		chk(fill_level, 14'h1);
		rd(2'h0, 10'h020);
		rd(2'h1, 10'h030);
		rd(2'h2, 10'h000);
		$display("reset values done");
		for (i = 0; i < 6; i++) begin
			wr(2'h0, 10'(i) << 3);
			chk(active_input, FX[i]);
			chk(chan_count, 14'h1);
		end
		$display("fixed selection done");
		// Only documented scan codes are programmed
		for (i = 0; i < 6; i++) begin
			wr(2'h0, SC[i]);
			chk(chan_count, 14'(SN[i]));
			chk(fill_level, 14'(SN[i]));
			for (k = 0; k < 2 * SN[i]; k++) begin
				chk(active_input, SQ[i][4 * (k % SN[i]) +: 4]);
				strobe();
			end
		end
		$display("autoscan done");
		for (i = 1; i < 4; i++) begin
			wr(2'h0, 10'h0C8 | (10'(i) << 8));
			chk(active_input, REFS[i - 1]);
			strobe();
			chk(active_input, REFS[i - 1]);
		end
		wr(2'h0, 10'h09D);
		chk(active_input, AP);
		chk(fill_level, 14'h4);
		chk(cr0_pins, 14'h5);
		$display("test inputs done");
		wr(2'h1, 10'h3FC);
		chk(cr1_pins, 14'h1F);
		chk(fill_level, 14'h0);
		rw_mode = 1'b1;
		rd(2'h1, 10'h1FC);
		wr(2'h1, 10'h001);
		rw_mode = 1'b0;
		@(negedge clk);
		rd(2'h0, 10'h020);
		rd(2'h1, 10'h030);
		$display("second register done");
		for (i = 0; i <= DEPTH; i++) begin
			k = $random(seed) & 3;
			wr(2'h0, 10'(k) << 3);
			tag = FX[k];
			strobe();
			push(10'($random(seed)));
		end
		chk(fifo_count, 14'(DEPTH));
		rd(2'h1, 10'h032);
		rd(2'h1, 10'h030);
		for (i = 0; i < 400 && sq.size() > 0; i++)
			@(negedge clk) sample_ready = 1'($random(seed));
		@(negedge clk) sample_ready = 1'b0;
		if (sq.size() > 0 || rq.size() > 0) begin
			err_count++;
			$display("unexpected at %0t: results still pending", $time);
		end
		chk(sample_valid, 14'h0);
		$display("queue and overflow done");
		tally_and_finish();
	end
endmodule
bind adcss_top adcss_top_props #(.FIFO_DEPTH(FIFO_DEPTH)) u_props (.*);
`default_nettype wire
